// ===== hdl/scio_ctrl.sv
// System command, status and pin control with serial register port.
// Assumes the host runs serial mode 3 and the capture engine is on clk.
`timescale 1ns/1ps
`default_nettype none
module scio_ctrl #(
  parameter logic [25:0] P_RESTORE   = 26'(scio_pkg::C_RESTORE),
  parameter logic [25:0] P_RESTORE_C = 26'(scio_pkg::C_RESTORE_C),
  parameter logic [25:0] P_SAVE      = 26'(scio_pkg::C_SAVE),
  parameter logic [25:0] P_SAVE_C    = 26'(scio_pkg::C_SAVE_C),
  parameter logic [25:0] P_CLRBUF    = 26'(scio_pkg::C_CLRBUF),
  parameter logic [25:0] P_SWRST     = 26'(scio_pkg::C_SWRST),
  parameter logic [25:0] P_FTEST     = 26'(scio_pkg::C_FTEST),
  parameter logic [25:0] P_FACTORY   = 26'(scio_pkg::C_FACTORY),
  parameter logic [25:0] P_STEST     = 26'(scio_pkg::C_STEST),
  parameter logic [25:0] P_NULL      = 26'(scio_pkg::C_NULL)
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  // Serial port
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe,
  // Digital pins
  input  wire logic        digital_pin_one_in,
  output logic             digital_pin_one_out,
  output logic             digital_pin_one_oe,
  input  wire logic        digital_pin_two_in,
  output logic             digital_pin_two_out,
  output logic             digital_pin_two_oe,
  // Capture engine
  input  wire logic        capture_active,
  input  wire logic        capture_done,
  output logic             capture_start,
  output logic             capture_stop,
  output logic             capture_ptr_clear,
  // Monitors and results
  input  wire logic [3:0]  alarm_exceed,
  input  wire logic [2:0]  event_source,
  input  wire logic        self_test_fail,
  input  wire logic        flash_sum_fail,
  input  wire logic        flash_update_fail,
  input  wire logic        supply_high,
  input  wire logic        supply_low,
  input  wire logic        flash_has_capture,
  // Command side effects
  output logic [15:0]      cmd_launch,
  output logic             cmd_active,
  output logic             self_test_enable
);
  localparam logic [25:0] P_SHORT = 26'(scio_pkg::C_CLRSTAT);
  localparam logic [25:0] P_PTR   = 26'(scio_pkg::C_PTR);

  ////////////////////////////////////////////////////////////////////////
  logic [4:0]  sync_q;
  logic        sclk_s;
  logic        cs_n_s;
  logic        mosi_s;
  logic        sclk_q_r;
  logic        cs_q_r;
  logic [15:0] rx_r;
  logic [15:0] tx_r;
  logic [15:0] txsh_r;
  logic [7:0]  bit_cnt_r;
  logic        cs_fall;
  logic        cs_rise;
  logic        frame_ok;
  logic        wr;
  logic [6:0]  waddr;
  logic        hi;
  logic [15:0] rd_data;

  scio_sync #(.W(5)) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    // Idle-high lines pass inverted so the reset value matches idle
    .d       ({~sclk, ~cs_n, mosi, digital_pin_two_in, digital_pin_one_in}),
    .q       (sync_q)
  );
  assign sclk_s   = ~sync_q[4];
  assign cs_n_s   = ~sync_q[3];
  assign mosi_s   = sync_q[2];
  assign cs_fall  = cs_q_r && !cs_n_s;
  assign cs_rise  = !cs_q_r && cs_n_s;
  assign frame_ok = cs_rise && (bit_cnt_r[3:0] == 4'h0) && (bit_cnt_r != 8'h00);
  assign wr       = frame_ok && rx_r[15];
  assign waddr    = {rx_r[14:9], 1'b0};
  assign hi       = rx_r[8];

  // Serial shifter, mode 3
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sclk_q_r  <= 1'b1;
      cs_q_r    <= 1'b1;
      rx_r      <= 16'h0000;
      txsh_r    <= 16'h0000;
      bit_cnt_r <= 8'h00;
      miso      <= 1'b0;
      miso_oe   <= 1'b0;
    end else if (ce) begin
      sclk_q_r <= sclk_s;
      cs_q_r   <= cs_n_s;
      miso_oe  <= !cs_n_s;
      if (cs_fall) begin
        bit_cnt_r <= 8'h00;
        miso      <= tx_r[15];
        // First falling edge presents the MSB again
        txsh_r    <= tx_r;
      end else if (!cs_n_s && sclk_s && !sclk_q_r) begin
        rx_r      <= {rx_r[14:0], mosi_s};
        bit_cnt_r <= bit_cnt_r + 8'h01;
      end else if (!cs_n_s && !sclk_s && sclk_q_r) begin
        miso   <= txsh_r[15];
        txsh_r <= {txsh_r[14:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic [5:0]  pincfg_r;
  logic [1:0]  gdir_r;
  logic [1:0]  glev_r;
  logic        stest_r;
  logic [15:0] cmd_r;
  logic [15:0] stat_r;
  logic        alarm_r;
  logic        wr_busy_r;
  logic        busy;
  logic        cfg_rst;
  logic [1:0]  pin_s;
  logic [15:0] cmd_set;

  assign pin_s = sync_q[1:0];
  assign cmd_set = !(wr && waddr == scio_pkg::ADDR_CMD) ? 16'h0000 :
                   (hi ? {rx_r[7:0], 8'h00} : {8'h00, rx_r[7:0]}) & scio_pkg::CMD_MASK;

  // Configuration registers
  always_ff @(posedge clk) begin
    if (!reset_n || (ce && cfg_rst)) begin
      pincfg_r <= scio_pkg::PINCFG_RST[5:0];
      gdir_r   <= 2'h0;
      glev_r   <= 2'h0;
      stest_r  <= 1'b0;
    end else if (ce && wr) begin
      if (waddr == scio_pkg::ADDR_PINCFG && !hi)
        pincfg_r <= rx_r[5:0];
      if (waddr == scio_pkg::ADDR_GPIO && !hi)
        gdir_r <= rx_r[1:0];
      if (waddr == scio_pkg::ADDR_GPIO && hi)
        glev_r <= rx_r[1:0];
      if (waddr == scio_pkg::ADDR_MISC && hi)
        stest_r <= rx_r[0];
    end
  end
  assign self_test_enable = stest_r;

  // Read data for the next frame
  always_comb begin
    case ({rx_r[14:9], 1'b0})
      scio_pkg::ADDR_GPIO:
        rd_data = {6'h00, (gdir_r & glev_r) | (~gdir_r & pin_s), 6'h00, gdir_r};
      scio_pkg::ADDR_MISC:   rd_data = {7'h00, stest_r, 8'h00};
      scio_pkg::ADDR_PINCFG: rd_data = {10'h000, pincfg_r};
      scio_pkg::ADDR_DIAG:   rd_data = stat_r;
      scio_pkg::ADDR_CMD:    rd_data = cmd_r;
      default:               rd_data = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_r      <= 16'h0000;
      wr_busy_r <= 1'b0;
    end else if (ce) begin
      wr_busy_r <= wr;
      if (frame_ok && !rx_r[15])
        tx_r <= rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  scio_pkg::scio_seq_e st_r;
  logic [3:0]  cur_r;
  logic [25:0] cnt_r;
  logic [25:0] dur;
  logic [3:0]  pick;
  logic        end_p;
  logic        clr_stat;
  logic        trig_any;
  logic [1:0]  trig_p;

  assign end_p    = (st_r == scio_pkg::SQ_END);
  assign clr_stat = end_p && cur_r == 4'(scio_pkg::CMD_CLRSTAT);
  assign cfg_rst  = end_p && (cur_r == 4'(scio_pkg::CMD_SWRST) ||
                              cur_r == 4'(scio_pkg::CMD_FACTORY));

  // Highest pending command goes first
  always_comb begin
    pick = 4'h0;
    for (int i = 0; i < 16; i++)
      if (cmd_r[i])
        pick = 4'(i);
  end

  always_comb begin
    case (pick)
      4'(scio_pkg::CMD_RESTORE): dur = flash_has_capture ? P_RESTORE_C : P_RESTORE;
      4'(scio_pkg::CMD_SAVE):    dur = flash_has_capture ? P_SAVE_C : P_SAVE;
      4'(scio_pkg::CMD_PTR):     dur = P_PTR;
      4'(scio_pkg::CMD_CLRBUF):  dur = P_CLRBUF;
      4'(scio_pkg::CMD_SWRST):   dur = P_SWRST;
      4'(scio_pkg::CMD_FTEST):   dur = P_FTEST;
      4'(scio_pkg::CMD_CLRSTAT): dur = P_SHORT;
      4'(scio_pkg::CMD_FACTORY): dur = P_FACTORY;
      4'(scio_pkg::CMD_STEST):   dur = P_STEST;
      4'(scio_pkg::CMD_NULL):    dur = P_NULL;
      default:                   dur = 26'h0000001;
    endcase
  end

  // Command sequencer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r       <= scio_pkg::SQ_IDLE;
      cur_r      <= 4'h0;
      cnt_r      <= 26'h0000000;
      cmd_launch <= 16'h0000;
    end else if (ce) begin
      cmd_launch <= 16'h0000;
      case (st_r)
        scio_pkg::SQ_IDLE: begin
          if (cmd_r != 16'h0000) begin
            cur_r             <= pick;
            cnt_r             <= dur - 26'h0000001;
            cmd_launch[pick]  <= 1'b1;
            st_r              <= scio_pkg::SQ_RUN;
          end
        end
        scio_pkg::SQ_RUN: begin
          if (cnt_r == 26'h0000000)
            st_r <= scio_pkg::SQ_END;
          else
            cnt_r <= cnt_r - 26'h0000001;
        end
        scio_pkg::SQ_END: st_r <= scio_pkg::SQ_IDLE;
        default:          st_r <= scio_pkg::SQ_IDLE;
      endcase
    end
  end

  // Pending commands, a new write wins over completion
  always_ff @(posedge clk) begin
    if (!reset_n)
      cmd_r <= 16'h0000;
    else if (ce)
      cmd_r <= (cmd_r & ~(end_p ? (16'h0001 << cur_r) : 16'h0000)) | cmd_set;
  end

  assign cmd_active        = (st_r != scio_pkg::SQ_IDLE);
  assign busy              = cmd_active || capture_active || wr_busy_r;
  assign trig_any          = |trig_p;
  assign capture_start     = (trig_any || (end_p && cur_r == 4'(scio_pkg::CMD_CAPT))) &&
                             !capture_active;
  assign capture_stop      = end_p && cur_r == 4'(scio_pkg::CMD_CAPT) && capture_active;
  assign capture_ptr_clear = end_p && cur_r == 4'(scio_pkg::CMD_PTR);

  ////////////////////////////////////////////////////////////////////////
  logic [15:0] st_set;

  always_comb begin
    st_set = 16'h0000;
    st_set[scio_pkg::ST_EVT_LO +: 3] = event_source;
    st_set[scio_pkg::ST_ALM_LO +: 4] = alarm_exceed;
    st_set[scio_pkg::ST_READY]       = capture_done;
    st_set[scio_pkg::ST_FTEST]       = end_p && cur_r == 4'(scio_pkg::CMD_FTEST) && flash_sum_fail;
    st_set[scio_pkg::ST_STEST]       = end_p && cur_r == 4'(scio_pkg::CMD_STEST) && self_test_fail;
    st_set[scio_pkg::ST_VIOL]        = cs_fall && capture_active;
    st_set[scio_pkg::ST_SPI]         = cs_rise && bit_cnt_r[3:0] != 4'h0;
    st_set[scio_pkg::ST_FLASH]       = flash_update_fail;
    st_set[scio_pkg::ST_SUPHI]       = supply_high;
    st_set[scio_pkg::ST_SUPLO]       = supply_low;
  end

  // Sticky flags, set wins over clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stat_r  <= 16'h0000;
      alarm_r <= 1'b0;
    end else if (ce) begin
      stat_r  <= ((clr_stat || capture_start) ? 16'h0000 : stat_r) | st_set;
      alarm_r <= (clr_stat ? 1'b0 : alarm_r) | (|alarm_exceed);
    end
  end

  scio_pin_mux u_pin_one (
    .clk        (clk),
    .reset_n    (reset_n),
    .ce         (ce),
    .func       (pincfg_r[3:2]),
    .pol        (pincfg_r[0]),
    .gp_dir     (gdir_r[0]),
    .gp_level   (glev_r[0]),
    .busy       (busy),
    .alarm      (alarm_r),
    .pin_in     (pin_s[0]),
    .pin_out    (digital_pin_one_out),
    .pin_oe     (digital_pin_one_oe),
    .trig_pulse (trig_p[0])
  );

  scio_pin_mux u_pin_two (
    .clk        (clk),
    .reset_n    (reset_n),
    .ce         (ce),
    .func       (pincfg_r[5:4]),
    .pol        (pincfg_r[1]),
    .gp_dir     (gdir_r[1]),
    .gp_level   (glev_r[1]),
    .busy       (busy),
    .alarm      (alarm_r),
    .pin_in     (pin_s[1]),
    .pin_out    (digital_pin_two_out),
    .pin_oe     (digital_pin_two_oe),
    .trig_pulse (trig_p[1])
  );

  ////////////////////////////////////////////////////////////////////////
  pincfg_reset_a: assert property (@(posedge clk) !reset_n |=> pincfg_r == 6'h0F)
    else $error("pin config reset value wrong");
  busy_cmd_a: assert property (@(posedge clk) disable iff (!reset_n)
    st_r == scio_pkg::SQ_RUN |-> busy)
    else $error("busy low during command");
  cmd_selfclear_a: assert property (@(posedge clk) disable iff (!reset_n)
    ce && end_p && cmd_set == 16'h0000 |=> !cmd_r[cur_r])
    else $error("command bit not cleared");
  stest_time_a: assert property (@(posedge clk) disable iff (!reset_n)
    ce && st_r == scio_pkg::SQ_IDLE && cmd_r != 16'h0000 && pick == 4'(scio_pkg::CMD_STEST)
    |=> cnt_r == P_STEST - 26'h0000001)
    else $error("self-test duration wrong");
  stat_sticky_a: assert property (@(posedge clk) disable iff (!reset_n)
    ce && stat_r[scio_pkg::ST_STEST] && !clr_stat && !capture_start |=> stat_r[scio_pkg::ST_STEST])
    else $error("sticky flag lost");
  alarm_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    ce && clr_stat && alarm_exceed == 4'h0 |=> !alarm_r ##0 stat_r[11:8] == 4'h0)
    else $error("status clear did not clear alarm");
  spi_count_a: assert property (@(posedge clk) disable iff (!reset_n)
    ce && cs_rise && bit_cnt_r[3:0] != 4'h0 |=> stat_r[scio_pkg::ST_SPI])
    else $error("clock count error not flagged");
  capt_viol_a: assert property (@(posedge clk) disable iff (!reset_n)
    ce && cs_fall && capture_active |=> stat_r[scio_pkg::ST_VIOL])
    else $error("capture violation not flagged");
  capt_toggle_a: assert property (@(posedge clk) disable iff (!reset_n)
    end_p && cur_r == 4'(scio_pkg::CMD_CAPT) |-> (capture_start ^ capture_stop))
    else $error("capture toggle failed");
endmodule : scio_ctrl
`default_nettype wire

// ===== hdl/scio_pin_mux.sv
// Function multiplexer and trigger qualifier for one digital pin.
// Assumes pin_in is already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module scio_pin_mux #(
  parameter int MIN_PULSE = scio_pkg::C_TRIG
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       ce,
  // Configuration
  input  wire logic [1:0] func,
  input  wire logic       pol,
  input  wire logic       gp_dir,
  input  wire logic       gp_level,
  // Block state
  input  wire logic       busy,
  input  wire logic       alarm,
  // Pin
  input  wire logic       pin_in,
  output logic            pin_out,
  output logic            pin_oe,
  output logic            trig_pulse
);
  localparam logic [scio_pkg::TRIG_W-1:0] MIN_C = scio_pkg::TRIG_W'(MIN_PULSE);
  logic                        act_q_r;
  logic [scio_pkg::TRIG_W-1:0] width_r;
  logic                        is_trig;
  logic                        act;

  assign is_trig = (func == scio_pkg::FN_TRIG);
  assign act     = is_trig && (pin_in == pol);

  // Output level and enable per selected function
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else if (ce) begin
      case (func)
        scio_pkg::FN_GPIO: begin
          pin_out <= gp_level;
          pin_oe  <= gp_dir;
        end
        scio_pkg::FN_ALARM: begin
          pin_out <= alarm ~^ pol;
          pin_oe  <= 1'b1;
        end
        scio_pkg::FN_BUSY: begin
          pin_out <= busy ~^ pol;
          pin_oe  <= 1'b1;
        end
        default: begin
          pin_out <= 1'b0;
          pin_oe  <= 1'b0;
        end
      endcase
    end
  end

  // Pulse width measure, fires on trailing edge
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      act_q_r    <= 1'b0;
      width_r    <= '0;
      trig_pulse <= 1'b0;
    end else if (ce) begin
      act_q_r    <= act;
      trig_pulse <= act_q_r && !act && (width_r >= MIN_C);
      if (act && !act_q_r)
        width_r <= scio_pkg::TRIG_W'(1);
      else if (act && width_r != '1)
        width_r <= width_r + scio_pkg::TRIG_W'(1);
    end
  end

  trig_width_a: assert property (@(posedge clk) disable iff (!reset_n)
    ce && act_q_r && !act && (width_r < MIN_C) |=> !trig_pulse)
    else $error("short trigger pulse accepted");
endmodule : scio_pin_mux
`default_nettype wire

// ===== hdl/scio_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs.
// Assumes inputs change slowly against clk.
`timescale 1ns/1ps
`default_nettype none
module scio_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_r <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : scio_sync
`default_nettype wire

// ===== include/scio_pkg.sv
// Constants for the system command and pin control block.
// Assumes a 40 MHz core clock; times are in ns, counts derived here.
`default_nettype none
package scio_pkg;
  localparam int          CLK_NS      = 25;
  localparam int          CNT_W       = 26;
  localparam int          TRIG_W      = 8;
  // Register byte addresses
  localparam logic [6:0]  ADDR_GPIO   = 7'h32;
  localparam logic [6:0]  ADDR_MISC   = 7'h34;
  localparam logic [6:0]  ADDR_PINCFG = 7'h36;
  localparam logic [6:0]  ADDR_DIAG   = 7'h3C;
  localparam logic [6:0]  ADDR_CMD    = 7'h3E;
  localparam logic [15:0] PINCFG_RST  = 16'h000F;
  localparam logic [15:0] CMD_MASK    = 16'h3DBF;
  // Command bit positions
  localparam int          CMD_RESTORE = 13;
  localparam int          CMD_SAVE    = 12;
  localparam int          CMD_CAPT    = 11;
  localparam int          CMD_PTR     = 10;
  localparam int          CMD_CLRBUF  = 8;
  localparam int          CMD_SWRST   = 7;
  localparam int          CMD_FTEST   = 5;
  localparam int          CMD_CLRSTAT = 4;
  localparam int          CMD_FACTORY = 3;
  localparam int          CMD_STEST   = 2;
  localparam int          CMD_PDOWN   = 1;
  localparam int          CMD_NULL    = 0;
  // Status bit positions
  localparam int          ST_EVT_LO   = 12;
  localparam int          ST_ALM_LO   = 8;
  localparam int          ST_READY    = 7;
  localparam int          ST_FTEST    = 6;
  localparam int          ST_STEST    = 5;
  localparam int          ST_VIOL     = 4;
  localparam int          ST_SPI      = 3;
  localparam int          ST_FLASH    = 2;
  localparam int          ST_SUPHI    = 1;
  localparam int          ST_SUPLO    = 0;
  // Execution times
  localparam int          T_RESTORE_NS   = 980_000;
  localparam int          T_RESTORE_C_NS = 7_000_000;
  localparam int          T_SAVE_NS      = 339_000_000;
  localparam int          T_SAVE_C_NS    = 509_000_000;
  localparam int          T_PTR_NS       = 35_000;
  localparam int          T_CLRBUF_NS    = 840_000;
  localparam int          T_SWRST_NS     = 54_000_000;
  localparam int          T_FTEST_NS     = 10_500_000;
  localparam int          T_CLRSTAT_NS   = 35_000;
  localparam int          T_FACTORY_NS   = 339_000_000;
  localparam int          T_STEST_NS     = 33_000_000;
  localparam int          T_NULL_NS      = 936_000_000;
  localparam int          T_TRIG_NS      = 2_600;
  localparam int          C_RESTORE   = (T_RESTORE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          C_RESTORE_C = (T_RESTORE_C_NS + CLK_NS - 1) / CLK_NS;
  localparam int          C_SAVE      = (T_SAVE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          C_SAVE_C    = (T_SAVE_C_NS + CLK_NS - 1) / CLK_NS;
  localparam int          C_PTR       = (T_PTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int          C_CLRBUF    = (T_CLRBUF_NS + CLK_NS - 1) / CLK_NS;
  localparam int          C_SWRST     = (T_SWRST_NS + CLK_NS - 1) / CLK_NS;
  localparam int          C_FTEST     = (T_FTEST_NS + CLK_NS - 1) / CLK_NS;
  localparam int          C_CLRSTAT   = (T_CLRSTAT_NS + CLK_NS - 1) / CLK_NS;
  localparam int          C_FACTORY   = (T_FACTORY_NS + CLK_NS - 1) / CLK_NS;
  localparam int          C_STEST     = (T_STEST_NS + CLK_NS - 1) / CLK_NS;
  localparam int          C_NULL      = (T_NULL_NS + CLK_NS - 1) / CLK_NS;
  localparam int          C_TRIG      = (T_TRIG_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    FN_GPIO  = 2'h0,
    FN_ALARM = 2'h1,
    FN_TRIG  = 2'h2,
    FN_BUSY  = 2'h3
  } scio_func_e;
  typedef enum logic [2:0] {
    SQ_IDLE = 3'h1,
    SQ_RUN  = 3'h2,
    SQ_END  = 3'h4
  } scio_seq_e;
endpackage : scio_pkg
`default_nettype wire

// ===== sim/scio_host.sv
// Host model: serial master, mode 3, 16-bit frames.
// Assumes the device samples the 200 ns link clock on clk.
`timescale 1ns/1ps
`default_nettype none
module scio_host (
  // Serial
  output logic        sclk,
  output logic        cs_n,
  output logic        mosi,
  input  wire logic   miso,
  // Result
  output logic [15:0] rd_word,
  output logic        rd_done
);
  initial {sclk, cs_n, mosi, rd_done} = 4'hE;
  // Frame of n clocks; chk marks a read result
  task automatic xfer(input logic [15:0] w, input int n, input bit chk);
    cs_n = 1'b0;
    #400;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = w[i%16];
      #100;
      sclk = 1'b1;
      rd_word = {rd_word[14:0], miso};
      #100;
    end
    mosi = ~mosi;
    #200;
    cs_n = 1'b1;
    rd_done = chk;
    #400;
    rd_done = 1'b0;
  endtask : xfer
endmodule : scio_host
`default_nettype wire

// ===== sim/tb.sv
// Bench for the command and pin control block.
// Assumes the serial host model drives the link.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, reset_n = 0, sclk, cs_n, mosi, miso, miso_oe, miso_w, rd_done, p1o, p1e, p2o, p2e;
  logic p2_drv = 0, cap, cact, mon = 0, cap_on = 0, stp, ste;
  logic [3:0] alm = 0;
  logic [15:0] rd_word;
  logic [1:0] v;
  int num_errors, checks, n_start, n_stop, r;
  logic [15:0] exp_q[$];
  always #12.5 clk = ~clk;
  assign miso_w = miso_oe ? miso : 1'b1;
  scio_host h (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_w), .rd_word(rd_word), .rd_done(rd_done));
  scio_ctrl #(.P_RESTORE(26'h14), .P_RESTORE_C(26'h14), .P_FTEST(26'h14), .P_STEST(26'h14))
    dut_u (.clk(clk), .reset_n(reset_n), .ce(1'b1),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .digital_pin_one_in(p1e ? p1o : 1'b0), .digital_pin_one_out(p1o), .digital_pin_one_oe(p1e),
    .digital_pin_two_in(p2e ? p2o : p2_drv), .digital_pin_two_out(p2o), .digital_pin_two_oe(p2e),
    .capture_active(cap_on), .capture_done(mon), .capture_start(cap), .capture_stop(stp), .capture_ptr_clear(),
    .alarm_exceed(alm), .event_source({3{mon}}), .self_test_fail(mon), .flash_sum_fail(mon),
    .flash_update_fail(mon), .supply_high(mon), .supply_low(mon), .flash_has_capture(mon),
    .cmd_launch(), .cmd_active(cact), .self_test_enable(ste));
  always @(posedge clk) if (cap) n_start++;
  always @(posedge clk) if (stp) n_stop++;
  always @(posedge rd_done) begin
    checks++;
    if (rd_word !== exp_q[0]) begin
      num_errors++;
      $display("[ERR] %0t read %h exp %h", $time, rd_word, exp_q[0]);
    end
    void'(exp_q.pop_front());
  end
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    h.xfer({1'b0, a, 8'h00}, 16, 1'b0);
    h.xfer(16'h0000, 16, 1'b1);
  endtask : rd
  task automatic ck(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t pin %b exp %b", $time, g, e);
    end
  endtask : ck
  task automatic idle;
    for (int i = 0; i < 3000 && cact !== 1'b0; i++) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask : idle
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin
    #1_000_000;
    num_errors++;
    end_sim();
  end
  initial begin
    r = $urandom(32'hC561);
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    rd(7'h36, 16'h000F);
    ck(p1e & ~p1o, 1'b1);
    $display("test reset done");
    h.xfer(16'hBF20, 16, 1'b0);
    ck(p1o, 1'b1);
    idle();
    ck(p1o, 1'b0);
    rd(7'h3E, 16'h0000);
    $display("test command done");
    h.xfer(16'hB62F, 16, 1'b0);
    n_start = 0;
    foreach (v[i]) begin
      @(negedge clk) p2_drv = 1'b1;
      repeat (i ? 110 + $urandom % 40 : 20 + $urandom % 60) @(negedge clk);
      p2_drv = 1'b0;
      repeat (10) @(negedge clk);
      ck(n_start == 1, 1'b1);
    end
    $display("test trigger done");
    h.xfer(16'hB61F, 16, 1'b0);
    @(negedge clk) {mon, alm} = 5'h11;
    @(negedge clk) {mon, alm} = 5'h00;
    h.xfer(16'h0000, 15, 1'b0);
    ck(p2o, 1'b1);
    rd(7'h3C, 16'h718F);
    h.xfer(16'hBE10, 16, 1'b0);
    idle();
    ck(p2o, 1'b0);
    rd(7'h3C, 16'h0000);
    $display("test status done");
    mon = 1'b1;
    h.xfer(16'hBE24, 16, 1'b0);
    idle();
    idle();
    mon = 1'b0;
    rd(7'h3C, 16'h70E7);
    $display("test self-test done");
    n_start = 0;
    h.xfer(16'hBF08, 16, 1'b0);
    idle();
    cap_on = 1'b1;
    h.xfer(16'hBF08, 16, 1'b0);
    idle();
    ck(p1o, 1'b1);
    cap_on = 1'b0;
    ck(n_start == 1 && n_stop == 1, 1'b1);
    rd(7'h3C, 16'h0010);
    $display("test capture done");
    v = 2'($urandom);
    h.xfer(16'hB600, 16, 1'b0);
    h.xfer(16'hB203, 16, 1'b0);
    h.xfer({14'h2CC0, v}, 16, 1'b0);
    ck(p2o, v[1]);
    ck(p1o, v[0]);
    rd(7'h32, {6'h00, v, 8'h03});
    h.xfer(16'hB201, 16, 1'b0);
    p2_drv = 1'b1;
    rd(7'h32, {6'h00, 1'b1, v[0], 8'h01});
    h.xfer(16'hB501, 16, 1'b0);
    ck(ste, 1'b1);
    $display("test gpio done");
    end_sim();
  end
endmodule : tb
`default_nettype wire
